// *** hw/wps_defines.vh ***
// Constants for the watchdog and power-fail supervisor
`ifndef WPS_DEFINES_VH
`define WPS_DEFINES_VH

// ==========================================================
// Register addresses
`define WPS_ADDR_CLOCK_CTRL    8'h8e
`define WPS_ADDR_DOG_CTRL      8'hd8
`define WPS_ADDR_EXT_IRQ_EN    8'he8
`define WPS_ADDR_TIMED_ACCESS  8'hc7

// ==========================================================
// Reset values
`define WPS_RST_CLOCK_CTRL     8'h01
`define WPS_RST_DOG_CTRL       8'h00
`define WPS_RST_EXT_IRQ_EN     8'h00

// ==========================================================
// Field positions
`define WPS_CK_SEL_HI          7
`define WPS_CK_SEL_LO          6
`define WPS_WD_PF_IRQ_EN       5
`define WPS_WD_PF_FLAG         4
`define WPS_WD_IRQ_FLAG        3
`define WPS_WD_RST_FLAG        2
`define WPS_WD_ENABLE          1
`define WPS_WD_RESTART         0
`define WPS_EIE_DOG_IRQ_EN     4

// ==========================================================
// Timed access
`define WPS_TA_KEY_FIRST       8'haa
`define WPS_TA_KEY_SECOND      8'h55
`define WPS_TA_OPEN_CLKS       4'hc

// ==========================================================
// Watchdog tail and vectors
`define WPS_DOG_TAIL_CLKS      27'h000_0200
`define WPS_VEC_POWER_FAIL     16'h0033
`define WPS_VEC_DOG            16'h0063

`endif

// *** hw/wps_sync.v ***
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module wps_sync #(
    parameter W = 2
) (
    input  wire         clk,
    input  wire         reset,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    genvar i;
    // ==========================================================
    // One chain per bit
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (reset) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate
    assign sync_out = stage2;
endmodule // wps_sync
`default_nettype wire

// *** hw/wps_por_delay.v ***
// Power-on delay counter, restarted while held
`timescale 1ns/1ps
`default_nettype none
module wps_por_delay #(
    parameter         W     = 17,
    parameter [W-1:0] COUNT = 17'h1_0000
) (
    input  wire clk,
    input  wire reset,
    input  wire hold,
    output reg  done
);
    localparam [W-1:0] LAST = COUNT - 1'b1;
    reg [W-1:0] cnt;
    // ==========================================================
    // Count whole delay after hold drops
    always @(posedge clk) begin
        if (reset || hold) begin
            cnt  <= {W{1'b0}};
            done <= 1'b0;
        end else if (!done) begin
            if (cnt == LAST) begin
                done <= 1'b1;
            end
            cnt <= cnt + 1'b1;
        end
    end
endmodule // wps_por_delay
`default_nettype wire

// *** hw/wps_supervisor.v ***
// Watchdog timer and power-fail supervisor with its register port
`timescale 1ns/1ps
`default_nettype none
`include "wps_defines.vh"
module wps_supervisor #(
    parameter [26:0] WD_LEN_0 = 27'h002_0000,
    parameter [26:0] WD_LEN_1 = 27'h010_0000,
    parameter [26:0] WD_LEN_2 = 27'h080_0000,
    parameter [26:0] WD_LEN_3 = 27'h400_0000,
    parameter [16:0] POR_CLKS = 17'h1_0000
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        supply_below_reset,
    input  wire        supply_below_warning,
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata,
    input  wire        other_irq_req,
    input  wire [15:0] other_irq_vector,
    output reg         cpu_reset,
    output reg         dog_irq_req,
    output reg         power_fail_irq,
    output reg         irq_req,
    output reg  [15:0] irq_vector,
    output reg  [7:0]  clock_control_reg
);
    // ==========================================================
    // Pin synchronisers
    wire [1:0] pins_s;
    wire       below_rst_s;
    wire       warning_s;
    wire       por_done;
    wire       chip_rst;

    wps_sync #(
        .W (2)
    ) u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({supply_below_warning, supply_below_reset}),
        .sync_out (pins_s)
    );
    assign below_rst_s = pins_s[0];
    assign warning_s   = pins_s[1];

    // ==========================================================
    // Power-on and brown-out reset
    wps_por_delay #(
        .W     (17),
        .COUNT (POR_CLKS)
    ) u_por (
        .clk   (clk),
        .reset (reset),
        .hold  (below_rst_s),
        .done  (por_done)
    );
    assign chip_rst = reset | ~por_done;

    // ==========================================================
    // Registers
    reg  [7:0] ext_irq_enable_reg;
    reg        pf_irq_en;
    reg        pf_flag;
    reg        dog_irq_flag;
    reg        dog_reset_flag;
    reg        dog_enable;
    reg        ta_armed;
    reg  [3:0] ta_open;
    reg [26:0] dog_cnt;
    reg        dog_fire;
    reg        warning_d;

    wire wr_ck  = sfr_wr && (sfr_addr == `WPS_ADDR_CLOCK_CTRL);
    wire wr_wd  = sfr_wr && (sfr_addr == `WPS_ADDR_DOG_CTRL);
    wire wr_eie = sfr_wr && (sfr_addr == `WPS_ADDR_EXT_IRQ_EN);
    wire wr_ta  = sfr_wr && (sfr_addr == `WPS_ADDR_TIMED_ACCESS);
    wire ta_ok  = (ta_open != 4'h0);

    // ==========================================================
    // Timed access window
    always @(posedge clk) begin
        if (chip_rst) begin
            ta_armed <= 1'b0;
            ta_open  <= 4'h0;
        end else if (wr_ta) begin
            ta_armed <= (sfr_wdata == `WPS_TA_KEY_FIRST);
            if (ta_armed && sfr_wdata == `WPS_TA_KEY_SECOND) begin
                ta_open <= `WPS_TA_OPEN_CLKS;
            end else begin
                ta_open <= 4'h0;
            end
        end else if (ta_ok) begin
            ta_open <= ta_open - 4'h1;
        end
    end

    // ==========================================================
    // Clock control and extended enable
    always @(posedge clk) begin
        if (chip_rst) begin
            clock_control_reg  <= `WPS_RST_CLOCK_CTRL;
            ext_irq_enable_reg <= `WPS_RST_EXT_IRQ_EN;
        end else begin
            if (wr_ck) begin
                clock_control_reg <= sfr_wdata;
            end
            if (wr_eie) begin
                ext_irq_enable_reg <= sfr_wdata;
            end
        end
    end

    // ==========================================================
    // Timeout length select
    reg [26:0] sel_len;
    always @* begin
        case ({clock_control_reg[`WPS_CK_SEL_HI],
               clock_control_reg[`WPS_CK_SEL_LO]})
            2'b00:   sel_len = WD_LEN_0;
            2'b01:   sel_len = WD_LEN_1;
            2'b10:   sel_len = WD_LEN_2;
            default: sel_len = WD_LEN_3;
        endcase
    end
    wire [26:0] irq_point = sel_len - 27'h000_0001;
    wire [26:0] rst_point = sel_len + `WPS_DOG_TAIL_CLKS - 27'h000_0001;

    // Restart only under timed access
    wire restart = wr_wd && ta_ok && sfr_wdata[`WPS_WD_RESTART];
    wire hit_irq = (dog_cnt == irq_point);
    wire hit_rst = (dog_cnt == rst_point);

    // ==========================================================
    // Watchdog counter
    always @(posedge clk) begin
        if (chip_rst) begin
            dog_cnt  <= 27'h000_0000;
            dog_fire <= 1'b0;
        end else begin
            dog_fire <= hit_rst && dog_enable;
            if (restart || hit_rst) begin
                dog_cnt <= 27'h000_0000;
            end else begin
                dog_cnt <= dog_cnt + 27'h000_0001;
            end
        end
    end

    // ==========================================================
    // Watchdog control register
    always @(posedge clk) begin
        if (chip_rst) begin
            pf_irq_en      <= 1'b0;
            pf_flag        <= 1'b0;
            dog_irq_flag   <= 1'b0;
            dog_reset_flag <= 1'b0;
            dog_enable     <= 1'b0;
            warning_d      <= 1'b0;
        end else begin
            warning_d <= warning_s;
            if (wr_wd) begin
                pf_irq_en <= sfr_wdata[`WPS_WD_PF_IRQ_EN];
                if (ta_ok) begin
                    dog_enable <= sfr_wdata[`WPS_WD_ENABLE];
                end
            end
            // Hardware set wins over software clear
            if (warning_s && !warning_d) begin
                pf_flag <= 1'b1;
            end else if (wr_wd && !sfr_wdata[`WPS_WD_PF_FLAG]) begin
                pf_flag <= 1'b0;
            end
            if (hit_irq && !restart) begin
                dog_irq_flag <= 1'b1;
            end else if (wr_wd && !sfr_wdata[`WPS_WD_IRQ_FLAG]) begin
                dog_irq_flag <= 1'b0;
            end
            if (dog_fire) begin
                dog_reset_flag <= 1'b1;
            end else if (wr_wd && !sfr_wdata[`WPS_WD_RST_FLAG]) begin
                dog_reset_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Processor reset
    always @(posedge clk) begin
        if (reset) begin
            cpu_reset <= 1'b1;
        end else begin
            cpu_reset <= ~por_done | dog_fire;
        end
    end

    // ==========================================================
    // Interrupt requests and priority
    wire dog_req_now = dog_irq_flag &&
                       ext_irq_enable_reg[`WPS_EIE_DOG_IRQ_EN];
    wire pf_req_now  = warning_s && pf_irq_en;

    always @(posedge clk) begin
        if (chip_rst) begin
            dog_irq_req    <= 1'b0;
            power_fail_irq <= 1'b0;
            irq_req        <= 1'b0;
            irq_vector     <= 16'h0000;
        end else begin
            dog_irq_req    <= dog_req_now;
            power_fail_irq <= pf_req_now;
            irq_req        <= pf_req_now | other_irq_req | dog_req_now;
            if (pf_req_now) begin
                irq_vector <= `WPS_VEC_POWER_FAIL;
            end else if (other_irq_req) begin
                irq_vector <= other_irq_vector;
            end else if (dog_req_now) begin
                irq_vector <= `WPS_VEC_DOG;
            end else begin
                irq_vector <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Read port
    wire [7:0] dog_ctrl_rd = {2'b00, pf_irq_en, pf_flag, dog_irq_flag,
                              dog_reset_flag, dog_enable, 1'b0};

    always @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `WPS_ADDR_CLOCK_CTRL: sfr_rdata <= clock_control_reg;
                `WPS_ADDR_DOG_CTRL:   sfr_rdata <= dog_ctrl_rd;
                `WPS_ADDR_EXT_IRQ_EN: sfr_rdata <= ext_irq_enable_reg;
                default:              sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule // wps_supervisor
`default_nettype wire

// *** tb/wps_supervisor_properties.sv ***
// Port assertions for the supervisor
`timescale 1ns/1ps
`default_nettype none
module wps_supervisor_properties #(
    parameter [16:0] POR_CLKS = 17'h1_0000
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        supply_below_reset,
    input wire logic        supply_below_warning,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        other_irq_req,
    input wire logic        cpu_reset,
    input wire logic        dog_irq_req,
    input wire logic        power_fail_irq,
    input wire logic        irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [7:0]  clock_control_reg
);
    // ========
    // Length of each reset hold
    logic [16:0] hi_cnt;
    always @(posedge clk) begin
        if (reset || !cpu_reset)
            hi_cnt <= 17'h0_0000;
        else
            hi_cnt <= hi_cnt + 17'h0_0001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ========
    // Checks
    property p_supply_hold;
        supply_below_reset [*5] |-> cpu_reset;
    endproperty
    a_supply_hold: assert property (p_supply_hold) else $error("no low supply hold");
    property p_por_length;
        $fell(cpu_reset) |-> hi_cnt == 17'h0_0001 || hi_cnt >= POR_CLKS;
    endproperty
    a_por_length: assert property (p_por_length) else $error("reset too short");
    property p_pf_vector;
        power_fail_irq && $past(power_fail_irq) |-> irq_req && irq_vector == 16'h0033;
    endproperty
    a_pf_vector: assert property (p_pf_vector) else $error("bad pf vector");
    property p_dog_vector;
        dog_irq_req && $past(dog_irq_req) && !power_fail_irq && !$past(power_fail_irq)
            && !$past(other_irq_req) |-> irq_req && irq_vector == 16'h0063;
    endproperty
    a_dog_vector: assert property (p_dog_vector) else $error("bad dog vector");
    property p_dog_mask;
        sfr_wr && sfr_addr == 8'he8 && !sfr_wdata[4] && !cpu_reset |-> ##2 !dog_irq_req;
    endproperty
    a_dog_mask: assert property (p_dog_mask) else $error("dog irq unmasked");
    property p_pf_disable;
        sfr_wr && sfr_addr == 8'hd8 && !sfr_wdata[5] && !cpu_reset |-> ##2 !power_fail_irq;
    endproperty
    a_pf_disable: assert property (p_pf_disable) else $error("pf irq not off");
    property p_pf_cause;
        power_fail_irq |-> $past(supply_below_warning, 3);
    endproperty
    a_pf_cause: assert property (p_pf_cause) else $error("pf irq no cause");
    property p_select_store;
        sfr_wr && sfr_addr == 8'h8e && !cpu_reset |-> ##2 clock_control_reg == $past(sfr_wdata, 2);
    endproperty
    a_select_store: assert property (p_select_store) else $error("select lost");
endmodule // wps_supervisor_properties
bind wps_supervisor wps_supervisor_properties #(.POR_CLKS(POR_CLKS)) i_wps_supervisor_properties (
    .clk(clk), .reset(reset), .supply_below_reset(supply_below_reset),
    .supply_below_warning(supply_below_warning), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .other_irq_req(other_irq_req), .cpu_reset(cpu_reset),
    .dog_irq_req(dog_irq_req), .power_fail_irq(power_fail_irq), .irq_req(irq_req),
    .irq_vector(irq_vector), .clock_control_reg(clock_control_reg));
`default_nettype wire

// *** tb/wps_supervisor_bench.sv ***
// Random and corner tests for the supervisor
`timescale 1ns/1ps
`default_nettype none
module wps_supervisor_bench;
    // ========
    // Signals
    logic        clk = 1'h0;
    logic        reset = 1'h1;
    logic        supply_below_reset = 1'h0;
    logic        supply_below_warning = 1'h0;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'h0;
    logic        sfr_rd = 1'h0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        other_irq_req = 1'h0;
    logic [15:0] other_irq_vector = 16'h0000;
    wire  [7:0]  sfr_rdata;
    wire  [7:0]  clock_control_reg;
    wire  [15:0] irq_vector;
    wire         cpu_reset;
    wire         dog_irq_req;
    wire         power_fail_irq;
    wire         irq_req;
    int          fails = 0;
    int          n_compared = 0;
    int          n;
    int          s;
    logic [7:0]  rdv;
    logic [7:0]  r8;
    logic        seen;
    always #5 clk = ~clk;
    wps_supervisor #(.WD_LEN_0(27'h000_0040), .WD_LEN_1(27'h000_0200),
        .WD_LEN_2(27'h000_1000), .WD_LEN_3(27'h000_8000), .POR_CLKS(17'h0_0040)
    ) i_wps_supervisor (.clk(clk), .reset(reset), .supply_below_reset(supply_below_reset),
        .supply_below_warning(supply_below_warning), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .other_irq_req(other_irq_req), .other_irq_vector(other_irq_vector),
        .cpu_reset(cpu_reset), .dog_irq_req(dog_irq_req), .power_fail_irq(power_fail_irq),
        .irq_req(irq_req), .irq_vector(irq_vector), .clock_control_reg(clock_control_reg));
    // ========
    // Helpers
    function automatic int exp_len(input int sel);
        return 64 << (3 * sel);
    endfunction
    task automatic report_and_stop;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'h1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sfr_rd <= 1'h1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_rd <= 1'h0;
        #1;
        rdv = sfr_rdata;
    endtask
    task automatic ta(input logic [7:0] d);
        wr(8'hc7, 8'haa);
        wr(8'hc7, 8'h55);
        wr(8'hd8, d);
    endtask
    task automatic wait_on(input logic dog, input logic lvl);
        n = 0;
        while ((dog ? dog_irq_req : cpu_reset) !== lvl && n < 40000) begin
            tick;
            n++;
        end
    endtask
    task automatic watch(input int c);
        repeat (c) begin
            tick;
            seen = seen | cpu_reset | dog_irq_req;
        end
    endtask
    // ========
    // Tests
    initial begin
        #600_000;
        fails++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h6d84_fdf6));
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        wait_on(1'h0, 1'h0);
        check(n >= 64 && n <= 70, 1);
        rd(8'hd8);
        check(rdv, 8'h00);
        rd(8'h8e);
        check(rdv, 8'h01);
        r8 = $urandom;
        wr(8'he8, r8 & 8'hef);
        wr(8'hd8, 8'h03);
        wr(8'hc7, 8'haa);
        wr(8'hd8, 8'h02);
        rd(8'hd8);
        check(rdv & 8'h03, 8'h00);
        seen = 1'h0;
        watch(700);
        check(seen, 0);
        rd(8'hd8);
        check(rdv & 8'h0c, 8'h08);
        ta(8'h03);
        wr(8'he8, r8 | 8'h10);
        seen = 1'h0;
        repeat (6) begin
            watch(40);
            ta(8'h03);
        end
        check(seen, 0);
        for (s = 0; s < 4; s++) begin
            r8 = $urandom;
            ta(8'h03);
            wr(8'h8e, {s[1:0], r8[5:0]});
            ta(8'h03);
            wait_on(1'h1, 1'h1);
            check(n >= exp_len(s) - 1 && n <= exp_len(s) + 3, 1);
            wait_on(1'h0, 1'h1);
            check(n >= 508 && n <= 516, 1);
            check(clock_control_reg, {s[1:0], r8[5:0]});
            rd(8'hd8);
            check(rdv, 8'h0e);
        end
        wr(8'hd8, 8'h00);
        rd(8'hd8);
        check(rdv & 8'h02, 8'h02);
        @(posedge clk);
        other_irq_vector <= 16'($urandom);
        other_irq_req <= 1'h1;
        supply_below_warning <= 1'h1;
        repeat (6) tick;
        check(power_fail_irq, 0);
        check(irq_vector, other_irq_vector);
        rd(8'hd8);
        check(rdv & 8'h30, 8'h10);
        wr(8'hd8, 8'h30);
        repeat (4) tick;
        check(power_fail_irq, 1);
        check(irq_vector, 16'h0033);
        @(posedge clk);
        supply_below_warning <= 1'h0;
        repeat (5) tick;
        rd(8'hd8);
        check(rdv & 8'h30, 8'h30);
        wr(8'hd8, 8'h00);
        rd(8'hd8);
        check(rdv & 8'h30, 8'h00);
        @(posedge clk);
        supply_below_reset <= 1'h1;
        repeat (10) tick;
        check(cpu_reset, 1);
        @(posedge clk);
        supply_below_reset <= 1'h0;
        wait_on(1'h0, 1'h0);
        check(n >= 64 && n <= 72, 1);
        rd(8'h8e);
        check(rdv, 8'h01);
        report_and_stop;
    end
endmodule // wps_supervisor_bench
`default_nettype wire
